// ### core/acb_defs.vh
`ifndef ACB_DEFS_VH
`define ACB_DEFS_VH
// --------------------------------------------------------------
// register offsets
// --------------------------------------------------------------
`define ACB_ADDR_PROT_GAIN 8'h01
`define ACB_ADDR_SWITCHING 8'h02
`define ACB_ADDR_SERIAL_PORT 8'h03
`define ACB_ADDR_CHAN_STATE 8'h04
`define ACB_ADDR_CHAN_VOLUME 8'h05
`define ACB_ADDR_CHECK_CTRL 8'h09
`define ACB_ADDR_CHECK_THRESH 8'h0A
// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define ACB_RST_PROT_GAIN 8'h32
`define ACB_RST_SWITCHING 8'h62
`define ACB_RST_SERIAL_PORT 8'h04
`define ACB_RST_CHAN_STATE 8'h55
`define ACB_RST_CHAN_VOLUME 8'hCF
`define ACB_RST_CHECK_CTRL 8'h00
`define ACB_RST_CHECK_THRESH 8'h11
// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define ACB_BIT_HIGHPASS_SKIP 7
`define ACB_BIT_OC_SEL 4
`define ACB_BIT_OVERSAMPLE 2
`define ACB_BIT_DIAG_ABORT 7
`define ACB_BIT_RAMP_DOUBLE 6
`define ACB_BIT_SETTLE_DOUBLE 5
`define ACB_BIT_LINE_OUT_EN 1
`define ACB_BIT_AUTO_SKIP 0
// --------------------------------------------------------------
// encodings
// --------------------------------------------------------------
`define ACB_STATE_PLAY 2'b00
`define ACB_STATE_HIZ 2'b01
`define ACB_STATE_MUTE 2'b10
`define ACB_STATE_DIAG 2'b11
`define ACB_VOL_MUTE_BELOW 8'h07
`define ACB_VOL_STEP_MAX 4'h8
`endif

// ### core/acb_volume_ramp.v
`include "acb_defs.vh"
// volume ramp: one 0.5 dB step per 1/2/4/8 frame syncs
module acb_volume_ramp (
  input wire clk_sys,
  input wire rst_n,
  input wire frame_sync,
  input wire [1:0] step_rate,
  input wire [7:0] target,
  output reg [7:0] applied_ff
);
  reg [2:0] cnt_ff;
  reg [2:0] nxt_cnt;
  reg [7:0] nxt_applied;
  wire [2:0] lim;
  // --------------------------------------------------------------
  // period select
  // --------------------------------------------------------------
  assign lim = (3'b001 << step_rate) - 3'b001; // R4
  // step only on frame sync, counting periods between steps
  always @*
  begin
    nxt_cnt = cnt_ff;
    nxt_applied = applied_ff;
    if (frame_sync)
    begin
      if (cnt_ff >= lim)
      begin
        nxt_cnt = 3'b000;
        if (applied_ff < target)
          nxt_applied = applied_ff + 8'h01; // R4
        else if (applied_ff > target)
          nxt_applied = applied_ff - 8'h01;
      end
      else
        nxt_cnt = cnt_ff + 3'b001;
    end
  end
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cnt_ff <= 3'b000;
      applied_ff <= `ACB_RST_CHAN_VOLUME;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      applied_ff <= nxt_applied;
    end
  end
endmodule // acb_volume_ramp

// ### core/acb_diag_seq.v
`include "acb_defs.vh"
// dc diagnostic request sequencer
module acb_diag_seq (
  input wire clk_sys,
  input wire rst_n,
  input wire [1:0] state_req,
  input wire auto_skip,
  input wire abort,
  input wire chan_fault,
  input wire diag_done,
  output reg diag_run_ff
);
  reg [1:0] prev_ff;
  wire leave_hiz;
  // leaving high impedance is the trigger, not staying out of it
  assign leave_hiz = (prev_ff == `ACB_STATE_HIZ) &&
                     (state_req != `ACB_STATE_HIZ);
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      prev_ff <= `ACB_STATE_HIZ;
      diag_run_ff <= 1'b0;
    end
    else
    begin
      prev_ff <= state_req;
      if (abort)
        diag_run_ff <= 1'b0; // R13
      else if (state_req == `ACB_STATE_DIAG)
        diag_run_ff <= 1'b1;
      else if (!auto_skip && (leave_hiz || chan_fault))
        diag_run_ff <= 1'b1; // R17
      else if (diag_done)
        diag_run_ff <= 1'b0;
    end
  end
endmodule // acb_diag_seq

// ### core/acb_config_bank.v
// Contract
// R1: highpass_skip 0 keeps high-pass filter, 1 bypasses it; resets 0.
// R2: warning level 00..11 picks 140,130,120,110 C; resets 01.
// R3: overcurrent select 0 is level 1, 1 is level 2; resets 1.
// R4: volume moves one step per 1,2,4,8 frame syncs; resets 00.
// R5: gain 00..11 picks 7.5,15,21,29 V peak; resets 10.
// R6: switching field: 000 8x,001 10x,101/110 38x,010-100 reserved; reset 110.
// R7: code 111 is 48x only at 44.1 kHz family; host avoids at 48k.
// R8: oversample bit 0 gives 64x, 1 gives 128x; resets 0.
// R9: slot select picks slot code+1; high codes only for eight-slot frames.
// R10: format field picks framing; 111 reserved; resets 100.
// R11: state request: play, high impedance, mute, dc diagnostics; resets 01.
// R12: volume 0.5 dB steps, below 0x07 mutes; resets 0xCF.
// R13: writing abort 1 stops diagnostics; host writes it back to 0.
// R14: ramp_double doubles diagnostic ramp time; resets 0.
// R15: settle_double doubles diagnostic settling time; resets 0.
// R16: line-output detection only while line_out_diag_en is 1.
// R17: auto_skip 0 runs diagnostics on leaving high impedance or fault.
// R18: short threshold in 0.5 ohm steps, code plus one; resets 0001.
// R19: multi-byte writes acknowledge each byte and advance pointer by one.
// R20: host writes reserved codes and bits only with reset values.
`include "acb_defs.vh"
module acb_config_bank (
  input wire clk_sys,
  input wire rst_n,
  // byte stream from the two-wire control bus front end
  input wire xfer_start,
  input wire addr_valid,
  input wire [7:0] addr_byte,
  input wire wr_valid,
  input wire [7:0] wr_byte,
  input wire rd_req,
  output reg ack_ff,
  output reg [7:0] rd_data_ff,
  // audio and diagnostic status
  input wire frame_sync,
  input wire chan_fault,
  input wire diag_done,
  // decoded controls
  output reg highpass_skip_ff,
  output reg [1:0] overtemp_warn_level_ff,
  output reg overcurrent_level_sel_ff,
  output reg [1:0] gain_sel_ff,
  output reg [2:0] pwm_rate_sel_ff,
  output reg modulator_oversample_ff,
  output reg [1:0] sample_rate_sel_ff,
  output reg [2:0] slot_sel_ff,
  output reg [2:0] input_format_ff,
  output reg [1:0] channel_state_req_ff,
  output reg [7:0] applied_volume_ff,
  output reg volume_mute_ff,
  output reg diag_run_ff,
  output reg ramp_double_ff,
  output reg settle_double_ff,
  output reg line_out_diag_en_ff,
  output reg [3:0] short_load_threshold_ff
);
  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  reg [7:0] prot_gain_ff;
  reg [7:0] switching_ff;
  reg [7:0] serial_port_ff;
  reg [7:0] chan_state_ff;
  reg [7:0] chan_volume_ff;
  reg [7:0] check_ctrl_ff;
  reg [7:0] check_thresh_ff;
  reg [7:0] ptr_ff;
  reg [7:0] nxt_ptr;
  wire [7:0] ramp_vol;
  wire diag_run_w;

  // unmapped addresses read zero and ignore writes
  function [7:0] acb_read_mux;
    input [7:0] a;
    input [7:0] r1, r2, r3, r4, r5, r9, r10;
    begin
      case (a)
        `ACB_ADDR_PROT_GAIN: acb_read_mux = r1;
        `ACB_ADDR_SWITCHING: acb_read_mux = r2;
        `ACB_ADDR_SERIAL_PORT: acb_read_mux = r3;
        `ACB_ADDR_CHAN_STATE: acb_read_mux = r4;
        `ACB_ADDR_CHAN_VOLUME: acb_read_mux = r5;
        `ACB_ADDR_CHECK_CTRL: acb_read_mux = r9;
        `ACB_ADDR_CHECK_THRESH: acb_read_mux = r10;
        default: acb_read_mux = 8'h00;
      endcase
    end
  endfunction

  // --------------------------------------------------------------
  // register pointer
  // --------------------------------------------------------------
  // pointer loads from the address byte, then advances per data byte
  always @*
  begin
    nxt_ptr = ptr_ff;
    if (addr_valid)
      nxt_ptr = addr_byte;
    else if (wr_valid || rd_req)
      nxt_ptr = ptr_ff + 8'h01; // R19
  end

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ptr_ff <= 8'h00;
      ack_ff <= 1'b0;
      rd_data_ff <= 8'h00;
    end
    else
    begin
      ptr_ff <= nxt_ptr;
      ack_ff <= addr_valid | wr_valid; // R19
      if (rd_req)
        rd_data_ff <= acb_read_mux(ptr_ff, prot_gain_ff, switching_ff,
          serial_port_ff, chan_state_ff, chan_volume_ff, check_ctrl_ff,
          check_thresh_ff);
    end
  end

  // --------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------
  // all bits stored as written; reserved codes are the host's care
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      prot_gain_ff <= `ACB_RST_PROT_GAIN; // R1 R2 R3 R4 R5
      switching_ff <= `ACB_RST_SWITCHING; // R6 R8
      serial_port_ff <= `ACB_RST_SERIAL_PORT; // R10
      chan_state_ff <= `ACB_RST_CHAN_STATE; // R11
      chan_volume_ff <= `ACB_RST_CHAN_VOLUME; // R12
      check_ctrl_ff <= `ACB_RST_CHECK_CTRL; // R14 R15 R16
      check_thresh_ff <= `ACB_RST_CHECK_THRESH; // R18
    end
    else if (wr_valid && !xfer_start)
    begin
      case (ptr_ff)
        `ACB_ADDR_PROT_GAIN: prot_gain_ff <= wr_byte;
        `ACB_ADDR_SWITCHING: switching_ff <= wr_byte; // R7
        `ACB_ADDR_SERIAL_PORT: serial_port_ff <= wr_byte;
        `ACB_ADDR_CHAN_STATE: chan_state_ff <= wr_byte;
        `ACB_ADDR_CHAN_VOLUME: chan_volume_ff <= wr_byte;
        `ACB_ADDR_CHECK_CTRL: check_ctrl_ff <= wr_byte; // R13
        `ACB_ADDR_CHECK_THRESH: check_thresh_ff <= wr_byte;
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------
  // ramp and diagnostic helpers
  // --------------------------------------------------------------
  acb_volume_ramp u_ramp (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .frame_sync(frame_sync),
    .step_rate(prot_gain_ff[3:2]),
    .target(chan_volume_ff),
    .applied_ff(ramp_vol)
  );

  acb_diag_seq u_diag (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .state_req(chan_state_ff[7:6]),
    .auto_skip(check_ctrl_ff[`ACB_BIT_AUTO_SKIP]),
    .abort(check_ctrl_ff[`ACB_BIT_DIAG_ABORT]),
    .chan_fault(chan_fault),
    .diag_done(diag_done),
    .diag_run_ff(diag_run_w)
  );

  // --------------------------------------------------------------
  // decoded outputs
  // --------------------------------------------------------------
  // registered copies so every output leaves from a flip-flop
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      highpass_skip_ff <= 1'b0;
      overtemp_warn_level_ff <= 2'b01;
      overcurrent_level_sel_ff <= 1'b1;
      gain_sel_ff <= 2'b10;
      pwm_rate_sel_ff <= 3'b110;
      modulator_oversample_ff <= 1'b0;
      sample_rate_sel_ff <= 2'b00;
      slot_sel_ff <= 3'b000;
      input_format_ff <= 3'b100;
      channel_state_req_ff <= `ACB_STATE_HIZ;
      applied_volume_ff <= `ACB_RST_CHAN_VOLUME;
      volume_mute_ff <= 1'b0;
      diag_run_ff <= 1'b0;
      ramp_double_ff <= 1'b0;
      settle_double_ff <= 1'b0;
      line_out_diag_en_ff <= 1'b0;
      short_load_threshold_ff <= 4'b0001;
    end
    else
    begin
      highpass_skip_ff <= prot_gain_ff[`ACB_BIT_HIGHPASS_SKIP]; // R1
      overtemp_warn_level_ff <= prot_gain_ff[6:5]; // R2
      overcurrent_level_sel_ff <= prot_gain_ff[`ACB_BIT_OC_SEL]; // R3
      gain_sel_ff <= prot_gain_ff[1:0]; // R5
      pwm_rate_sel_ff <= switching_ff[6:4]; // R6
      modulator_oversample_ff <= switching_ff[`ACB_BIT_OVERSAMPLE]; // R8
      sample_rate_sel_ff <= serial_port_ff[7:6];
      slot_sel_ff <= serial_port_ff[5:3]; // R9
      input_format_ff <= serial_port_ff[2:0]; // R10
      channel_state_req_ff <= chan_state_ff[7:6]; // R11
      applied_volume_ff <= ramp_vol; // R4
      volume_mute_ff <= (ramp_vol < `ACB_VOL_MUTE_BELOW); // R12
      diag_run_ff <= diag_run_w; // R17
      ramp_double_ff <= check_ctrl_ff[`ACB_BIT_RAMP_DOUBLE]; // R14
      settle_double_ff <= check_ctrl_ff[`ACB_BIT_SETTLE_DOUBLE]; // R15
      line_out_diag_en_ff <= check_ctrl_ff[`ACB_BIT_LINE_OUT_EN]; // R16
      short_load_threshold_ff <= check_thresh_ff[7:4]; // R18
    end
  end
endmodule // acb_config_bank

// ### verification/acb_host_model.sv
module acb_host_model (
  input logic clk_sys,
  input logic ack_ff,
  input logic [7:0] rd_data_ff,
  output logic xfer_start,
  output logic addr_valid,
  output logic [7:0] addr_byte,
  output logic wr_valid,
  output logic [7:0] wr_byte,
  output logic rd_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // control bus master, k: 0 pointer, 1 write, 2 read
  // ------------------------------------------------------------
  initial {xfer_start, addr_valid, wr_valid, rd_req} = 4'h0;
  // released lanes show the inverse so a stale byte cannot pass
  task automatic op(input int k, input logic [7:0] v, output logic [7:0] r);
    xfer_start <= (k == 0);
    addr_valid <= (k == 0);
    wr_valid <= (k == 1);
    rd_req <= (k == 2);
    addr_byte <= v;
    wr_byte <= v;
    @(posedge clk_sys);
    {xfer_start, addr_valid, wr_valid, rd_req} <= 4'h0;
    addr_byte <= ~v;
    wr_byte <= ~v;
    // answer launched at the taking edge is read at the next one
    @(posedge clk_sys);
    r = (k == 2) ? rd_data_ff : {7'h00, ack_ff};
  endtask
endmodule // acb_host_model

// ### verification/acb_config_bank_props.sv
module acb_props (
  input logic clk_sys,
  input logic rst_n,
  input logic xfer_start,
  input logic addr_valid,
  input logic [7:0] addr_byte,
  input logic wr_valid,
  input logic [7:0] wr_byte,
  input logic rd_req,
  input logic ack_ff,
  input logic [7:0] rd_data_ff,
  input logic frame_sync,
  input logic [1:0] gain_sel_ff,
  input logic [1:0] channel_state_req_ff,
  input logic [7:0] applied_volume_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // bus answers and decoded field timing
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_ack_follows: assert property (addr_valid |=> ack_ff)
    else $error("no ack after pointer byte");
  a_ack_cause: assert property (ack_ff |-> $past(addr_valid | wr_valid))
    else $error("ack without request");
  a_gain_hold: assert property ($changed(gain_sel_ff)
    |-> $past(wr_valid, 2))
    else $error("gain moved without a write");
  a_vol_one_step: assert property ($changed(applied_volume_ff) |->
    (applied_volume_ff - $past(applied_volume_ff) == 8'h01 ||
    $past(applied_volume_ff) - applied_volume_ff == 8'h01))
    else $error("volume moved more than one step");
  a_vol_on_sync: assert property ($changed(applied_volume_ff) |->
    ($past(frame_sync) || $past(frame_sync, 2) || $past(frame_sync, 3)))
    else $error("volume moved without frame sync");
  a_read_hold: assert property (!rd_req |=> $stable(rd_data_ff))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (addr_valid && addr_byte == 8'h06
    ##1 !(addr_valid || wr_valid || rd_req) ##1 rd_req && !addr_valid
    |=> rd_data_ff == 8'h00)
    else $error("unmapped read not zero");
  a_state_decode: assert property (addr_valid && addr_byte == 8'h04
    ##1 !(addr_valid || wr_valid || rd_req)
    ##1 wr_valid && !addr_valid && !xfer_start
    |-> ##2 channel_state_req_ff == $past(wr_byte[7:6], 2))
    else $error("state request not decoded");
endmodule // acb_props
bind acb_config_bank acb_props u_acb_props (.clk_sys, .rst_n, .xfer_start,
  .addr_valid, .addr_byte, .wr_valid, .wr_byte, .rd_req, .ack_ff, .rd_data_ff,
  .frame_sync, .gain_sel_ff, .channel_state_req_ff, .applied_volume_ff);

// ### verification/amp_control_config_bank_bench.sv
module amp_control_config_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_n, frame_sync, chan_fault, diag_done, xfer_start;
  logic addr_valid, wr_valid, rd_req, ack_ff, highpass_skip_ff, volume_mute_ff;
  logic overcurrent_level_sel_ff, modulator_oversample_ff, diag_run_ff;
  logic ramp_double_ff, settle_double_ff, line_out_diag_en_ff;
  logic [7:0] addr_byte, wr_byte, rd_data_ff, applied_volume_ff;
  logic [1:0] overtemp_warn_level_ff, gain_sel_ff, sample_rate_sel_ff;
  logic [1:0] channel_state_req_ff;
  logic [2:0] pwm_rate_sel_ff, slot_sel_ff, input_format_ff;
  logic [3:0] short_load_threshold_ff;
  logic [7:0] wb [7];
  logic [7:0] obs [7];
  int mismatches, num_checks;
  localparam logic [7:0] rv [7] = '{8'h32, 8'h62, 8'h04, 8'h55, 8'hcf, 8'h00,
    8'h11};
  localparam logic [7:0] om [7] = '{8'hf3, 8'h74, 8'hff, 8'hc0, 8'hff, 8'h62,
    8'hf0};
  localparam logic [7:0] vt [4] = '{8'h06, 8'h07, 8'h0a, 8'h06};
  localparam logic [2:0] pc [5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7};
  localparam logic [15:0] dw [12] = '{16'h0455, 16'h0900, 16'h0415, 16'h0415,
    16'h0415, 16'h0415, 16'h0901, 16'h0455, 16'h0415, 16'h04d5, 16'h0981,
    16'h0901};
  localparam int dc [12] = '{4, 4, 1, 4, 3, 4, 0, 0, 2, 1, 0, 1};
  // ------------------------------------------------------------
  // decoded outputs gathered in register layout
  // ------------------------------------------------------------
  assign obs[0] = {highpass_skip_ff, overtemp_warn_level_ff,
    overcurrent_level_sel_ff, 2'h0, gain_sel_ff};
  assign obs[1] = {1'h0, pwm_rate_sel_ff, 1'h0, modulator_oversample_ff, 2'h0};
  assign obs[2] = {sample_rate_sel_ff, slot_sel_ff, input_format_ff};
  assign obs[3] = {channel_state_req_ff, 6'h00};
  assign obs[4] = applied_volume_ff;
  assign obs[5] = {1'h0, ramp_double_ff, settle_double_ff, 3'h0,
    line_out_diag_en_ff, 1'h0};
  assign obs[6] = {short_load_threshold_ff, 4'h0};
  acb_config_bank u_acb_config_bank (.clk_sys, .rst_n, .xfer_start,
    .addr_valid, .addr_byte, .wr_valid, .wr_byte, .rd_req, .ack_ff,
    .rd_data_ff, .frame_sync,
    .chan_fault, .diag_done, .highpass_skip_ff, .overtemp_warn_level_ff,
    .overcurrent_level_sel_ff, .gain_sel_ff, .pwm_rate_sel_ff,
    .modulator_oversample_ff, .sample_rate_sel_ff, .slot_sel_ff,
    .input_format_ff, .channel_state_req_ff, .applied_volume_ff,
    .volume_mute_ff, .diag_run_ff, .ramp_double_ff, .settle_double_ff,
    .line_out_diag_en_ff, .short_load_threshold_ff);
  acb_host_model u_acb_host_model (.clk_sys, .ack_ff, .rd_data_ff, .xfer_start,
    .addr_valid, .addr_byte, .wr_valid, .wr_byte, .rd_req);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // pointer byte, then wb[lo..hi] written or read back in one burst
  task automatic xs(input logic [7:0] a, input int lo, input int hi,
    input bit rd);
    logic [7:0] r;
    u_acb_host_model.op(0, a, r);
    chk("ptr ack", 8'h01, r);
    for (int j = lo; j <= hi; j++)
    begin
      u_acb_host_model.op(rd ? 2 : 1, wb[j], r);
      chk("burst", rd ? wb[j] : 8'h01, r);
    end
  endtask
  task automatic wr1(input logic [7:0] a, input logic [7:0] v);
    wb[0] = v;
    xs(a, 0, 0, 0);
  endtask
  // worst case frame syncs for the ramp to reach its target
  function automatic int syncs(input logic [7:0] a, input logic [7:0] b,
    input int r);
    return int'(a > b ? a - b : b - a) << r;
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  // whole run is near 1500 cycles, so this only trips on a hang
  initial
  begin
    #400_000;
    mismatches++;
    summarize;
  end
  initial
  begin
    logic [2:0] pw;
    {rst_n, frame_sync, chan_fault, diag_done} = 4'h0;
    void'($urandom(8));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    wb = rv;
    xs(8'h01, 0, 4, 1);
    xs(8'h09, 5, 6, 1);
    for (int j = 0; j < 7; j++)
      chk("reset", rv[j] & om[j], obs[j]);
    $display("test reset values done");
    for (int i = 0; i < 8; i++)
    begin
      pw = pc[i % 5];
      wb[0] = 8'($urandom);
      wb[1] = {1'h0, pw, 1'h0, 1'($urandom), 2'h2};
      // 48x only at the 44.1 kHz family; cleared one pass early too,
      // since the burst writes switching before the sample rate
      wb[2] = {pw[2:1] == 2'h3 ? 2'h0 : 2'($urandom_range(2)),
        3'(i), 3'(i % 7)};
      wb[3] = {2'(i), 6'h15};
      wb[4] = 8'($urandom);
      wb[5] = {1'h0, 2'($urandom), 3'h0, 2'($urandom)};
      wb[6] = {4'($urandom), 4'h1};
      xs(8'h01, 0, 4, 0);
      xs(8'h09, 5, 6, 0);
      xs(8'h01, 0, 3, 1);
      xs(8'h09, 5, 6, 1);
      for (int j = 0; j < 7; j++)
        if (j != 4)
          chk("decode", wb[j] & om[j], obs[j]);
    end
    $display("test field decode done");
    for (int r = 0; r < 4; r++)
    begin
      wr1(8'h01, 8'h32 | 8'(r << 2));
      wr1(8'h05, vt[r]);
      repeat (syncs(r == 0 ? 8'hcf : vt[r - 1], vt[r], r))
      begin
        repeat (3) @(posedge clk_sys);
        frame_sync <= 1'h1;
        @(posedge clk_sys);
        frame_sync <= 1'h0;
      end
      repeat (4) @(posedge clk_sys);
      chk("volume", vt[r], applied_volume_ff);
      chk("mute", 8'(vt[r] < 8'h07), 8'(volume_mute_ff));
    end
    $display("test volume ramp done");
    for (int s = 0; s < 12; s++)
    begin
      wr1(dw[s][15:8], dw[s][7:0]);
      repeat (3) @(posedge clk_sys);
      chan_fault <= (dc[s] / 2 == 1);
      diag_done <= (dc[s] / 2 == 2);
      @(posedge clk_sys);
      {chan_fault, diag_done} <= 2'h0;
      repeat (4) @(posedge clk_sys);
      chk("diag run", 8'(dc[s] % 2), 8'(diag_run_ff));
    end
    wr1(8'h06, 8'ha5);
    wb[0] = 8'h00;
    xs(8'h06, 0, 0, 1);
    $display("test diagnostics and unmapped done");
    summarize;
  end
endmodule // amp_control_config_bank_bench
